// [logic/pci_master_pkg.sv]
// Shared constants, field layouts and types for the master user port
package pci_master_pkg;
   // Register offsets and control bits
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam int CTRL_ADDR64_BIT = 0;
   localparam int CTRL_DATA64_BIT = 1;
   localparam int CTRL_HOLD_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   // Status register fields
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_ERR_LSB = 4;
   localparam int STAT_READY_BIT = 8;
   localparam int STAT_WR_ACTIVE_BIT = 9;
   localparam int STAT_RD_ACTIVE_BIT = 10;
   // State counter codes seen by user logic
   localparam logic [2:0] CNT_IDLE = 3'h0;
   localparam logic [2:0] CNT_SETUP1 = 3'h1;
   localparam logic [2:0] CNT_SETUP2 = 3'h2;
   localparam logic [2:0] CNT_DATA_LO = 3'h4;
   localparam logic [2:0] CNT_DATA_HI = 3'h5;
   // Setup word layout
   localparam int CMD_LSB = 32;
   localparam int CMD_WRITE_BIT = 32;
   localparam int RD_BE_LSB = 18;
   localparam int BURST_W = 18;
   localparam int SINGLE_ADDR_BIT = 2;
   // FIFO and timing figures
   localparam int FIFO_DEPTH = 64;
   localparam int ALMOST_LEVEL = 4;
   localparam int READY_HOLD_CYC = 9;
   localparam int STATUS_BITS = 3;
   localparam logic [31:0] DWORD_STEP = 32'h0000_0004;

   typedef enum logic [2:0] {S_IDLE, S_SETUP1, S_SETUP2, S_DATA_LO, S_DATA_HI} seq_state_e;

   typedef struct packed {
      logic last_n;
      logic [3:0] be;
      logic [31:0] data;
   } wr_entry_s;
endpackage

// [logic/pci_master_user_port.sv]
// User-side master port: setup sequencer, master FIFOs, status shifter, clear
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module pci_master_user_port #(
   parameter int DEPTH = pci_master_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // User setup and write side
   input wire logic addr_en_n_i,
   input wire logic write_data_en_n_i,
   input wire logic write_last_n_i,
   input wire logic [35:0] write_data_i,
   output logic [2:0] state_counter_o,
   output logic write_fifo_almost_full_o,
   output logic write_fifo_full_o,
   output logic write_fifo_empty_n_o,
   // User read side
   input wire logic read_data_en_n_i,
   output logic [31:0] read_data_o,
   output logic read_fifo_almost_empty_n_o,
   output logic read_fifo_empty_n_o,
   output logic read_fifo_full_n_o,
   input wire logic burst_stop_n_i,
   output logic termination_done_n_o,
   // Status and clear
   input wire logic status_shift_en_n_i,
   output logic error_status_o,
   input wire logic master_side_clear_n_i,
   output logic master_ready_o,
   // PCI engine side
   input wire logic [2:0] pci_status_i,
   output logic pci_wr_req_o,
   input wire logic pci_wr_pop_i,
   output pci_master_pkg::wr_entry_s pci_wr_entry_o,
   output logic pci_wr_entry_valid_o,
   output logic pci_rd_req_o,
   input wire logic pci_rd_push_i,
   input wire logic [31:0] pci_rd_data_i,
   input wire logic pci_abort_i,
   output logic [63:0] pci_addr_o,
   output logic [3:0] pci_cmd_o,
   output logic [7:0] pci_be_o,
   output logic pci_burst_o,
   output logic pci_wait_o,
   output logic pci_stop_o
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [CW-1:0] ALMOST_CNT = CW'(pci_master_pkg::ALMOST_LEVEL);
   localparam logic [CW-1:0] AFULL_CNT = CW'(DEPTH - pci_master_pkg::ALMOST_LEVEL);

   generate
      if (DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
         $error("DEPTH must be a power of two of at least 8");
      end
   endgenerate

   function automatic logic [2:0] state_code(input pci_master_pkg::seq_state_e s);
      case (s)
         pci_master_pkg::S_SETUP1: state_code = pci_master_pkg::CNT_SETUP1;
         pci_master_pkg::S_SETUP2: state_code = pci_master_pkg::CNT_SETUP2;
         pci_master_pkg::S_DATA_LO: state_code = pci_master_pkg::CNT_DATA_LO;
         pci_master_pkg::S_DATA_HI: state_code = pci_master_pkg::CNT_DATA_HI;
         default: state_code = pci_master_pkg::CNT_IDLE;
      endcase
   endfunction

   function automatic logic [CW-1:0] count_next(input logic [CW-1:0] c, input logic inc, input logic dec);
      count_next = c + CW'(inc) - CW'(dec);
   endfunction

   pci_master_pkg::seq_state_e state_reg, state_next;
   logic [2:0] ctrl_reg;
   logic soft_rst;
   logic is_read_reg;
   logic [63:0] addr_reg;
   logic [3:0] cmd_reg;
   logic [7:0] rd_be_reg;
   logic [pci_master_pkg::BURST_W-1:0] qw_reg;
   logic [pci_master_pkg::BURST_W:0] pci_left_reg;
   logic rd_active_reg;
   logic stop_seen_reg;
   logic last_queued_reg;
   logic [3:0] ready_cnt_reg;
   logic [1:0] shift_idx_reg;
   pci_master_pkg::wr_entry_s wr_mem [DEPTH];
   logic [31:0] rd_mem [DEPTH];
   logic [AW-1:0] wr_wp_reg, wr_rp_reg, rd_wp_reg, rd_rp_reg;
   logic [CW-1:0] wr_cnt_reg, rd_cnt_reg, wr_cnt_next, rd_cnt_next;
   logic wr_push, wr_pop, rd_push, rd_pop, rd_setup_done, rd_end;
   logic addr64, data64, hold, ae, wb_req;
   logic [pci_master_pkg::BURST_W-1:0] qw_eff;

   assign soft_rst = rst_i | ~master_side_clear_n_i;
   assign addr64 = ctrl_reg[pci_master_pkg::CTRL_ADDR64_BIT];
   assign data64 = ctrl_reg[pci_master_pkg::CTRL_DATA64_BIT];
   assign hold = ctrl_reg[pci_master_pkg::CTRL_HOLD_BIT];
   assign ae = ~addr_en_n_i;
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Address bit 2 set means one quadword regardless of the requested length
   assign qw_eff = write_data_i[pci_master_pkg::SINGLE_ADDR_BIT] ? pci_master_pkg::BURST_W'(1) : qw_reg;

   // Setup and data sequencer
   always_comb begin
      state_next = state_reg;
      wr_push = 1'b0;
      rd_pop = 1'b0;
      rd_setup_done = 1'b0;
      case (state_reg)
         pci_master_pkg::S_IDLE: begin
            if (ae) begin
               if (!write_data_i[pci_master_pkg::CMD_WRITE_BIT]) begin
                  state_next = pci_master_pkg::S_SETUP1;
               end else begin
                  state_next = addr64 ? pci_master_pkg::S_SETUP1 : pci_master_pkg::S_DATA_LO;
               end
            end
         end
         pci_master_pkg::S_SETUP1: begin
            if (ae) begin
               if (is_read_reg && addr64) begin
                  state_next = pci_master_pkg::S_SETUP2;
               end else begin
                  state_next = pci_master_pkg::S_DATA_LO;
               end
               rd_setup_done = is_read_reg;
            end
         end
         pci_master_pkg::S_SETUP2: begin
            if (ae) begin
               state_next = pci_master_pkg::S_DATA_LO;
            end
         end
         pci_master_pkg::S_DATA_LO, pci_master_pkg::S_DATA_HI: begin
            if (!is_read_reg) begin
               // Words offered while full are refused
               if (!write_data_en_n_i && wr_cnt_reg != FULL_CNT) begin
                  wr_push = 1'b1;
                  if (!write_last_n_i) begin
                     state_next = pci_master_pkg::S_IDLE;
                  end else if (state_reg == pci_master_pkg::S_DATA_LO && data64) begin
                     state_next = pci_master_pkg::S_DATA_HI;
                  end else begin
                     state_next = pci_master_pkg::S_DATA_LO;
                  end
               end
            end else begin
               rd_pop = !read_data_en_n_i && rd_cnt_reg != '0;
               if (!rd_active_reg && (rd_cnt_reg == '0 || (rd_pop && rd_cnt_reg == CW'(1)))) begin
                  state_next = pci_master_pkg::S_IDLE;
               end else if (rd_pop) begin
                  state_next = (state_reg == pci_master_pkg::S_DATA_LO && data64) ?
                     pci_master_pkg::S_DATA_HI : pci_master_pkg::S_DATA_LO;
               end
            end
         end
         default: state_next = pci_master_pkg::S_IDLE;
      endcase
   end

   assign wr_pop = pci_wr_pop_i && wr_cnt_reg != '0;
   assign rd_push = pci_rd_push_i && rd_active_reg && rd_cnt_reg != FULL_CNT;
   assign wr_cnt_next = count_next(wr_cnt_reg, wr_push, wr_pop);
   assign rd_cnt_next = count_next(rd_cnt_reg, rd_push, rd_pop);
   // Stop completes only once the FIFO has room again
   assign rd_end = rd_active_reg && (pci_abort_i || (rd_push && pci_left_reg == (pci_master_pkg::BURST_W + 1)'(1))
      || (!burst_stop_n_i && rd_cnt_reg != FULL_CNT));

   always_ff @(posedge clk_i) begin
      if (soft_rst) begin
         state_reg <= pci_master_pkg::S_IDLE;
         state_counter_o <= pci_master_pkg::CNT_IDLE;
      end else begin
         state_reg <= state_next;
         state_counter_o <= state_code(state_next);
      end
   end

   // Setup word capture
   always_ff @(posedge clk_i) begin
      if (soft_rst) begin
         is_read_reg <= 1'b0;
         addr_reg <= '0;
         cmd_reg <= '0;
         rd_be_reg <= '0;
         qw_reg <= '0;
      end else begin
         if (state_reg == pci_master_pkg::S_IDLE && ae) begin
            is_read_reg <= ~write_data_i[pci_master_pkg::CMD_WRITE_BIT];
            cmd_reg <= write_data_i[35:pci_master_pkg::CMD_LSB];
            addr_reg[63:32] <= '0;
            if (!write_data_i[pci_master_pkg::CMD_WRITE_BIT]) begin
               rd_be_reg <= write_data_i[pci_master_pkg::RD_BE_LSB +: 8];
               qw_reg <= write_data_i[pci_master_pkg::BURST_W-1:0];
            end else begin
               addr_reg[31:0] <= write_data_i[31:0];
            end
         end else if (state_reg == pci_master_pkg::S_SETUP1 && ae) begin
            if (is_read_reg) begin
               addr_reg[31:0] <= write_data_i[31:0];
            end else begin
               addr_reg[63:32] <= write_data_i[31:0];
            end
         end else if (state_reg == pci_master_pkg::S_SETUP2 && ae) begin
            addr_reg[63:32] <= write_data_i[31:0];
         end else if (rd_push) begin
            // Advance so a retried transaction resumes where it stopped
            addr_reg <= addr_reg + {32'h0, pci_master_pkg::DWORD_STEP};
         end
      end
   end

   // Read transaction tracking and termination
   always_ff @(posedge clk_i) begin
      if (soft_rst) begin
         rd_active_reg <= 1'b0;
         pci_left_reg <= '0;
         stop_seen_reg <= 1'b0;
         termination_done_n_o <= 1'b1;
      end else begin
         if (rd_setup_done) begin
            pci_left_reg <= {qw_eff, 1'b0};
         end else if (rd_push) begin
            pci_left_reg <= pci_left_reg - (pci_master_pkg::BURST_W + 1)'(1);
         end
         if (rd_end) begin
            rd_active_reg <= 1'b0;
         end else if ((state_reg == pci_master_pkg::S_SETUP1 || state_reg == pci_master_pkg::S_SETUP2)
            && state_next == pci_master_pkg::S_DATA_LO && is_read_reg) begin
            rd_active_reg <= 1'b1;
         end
         stop_seen_reg <= !burst_stop_n_i && (stop_seen_reg || rd_active_reg);
         termination_done_n_o <= !(stop_seen_reg && !burst_stop_n_i && (rd_end || !rd_active_reg));
      end
   end

   // Master write FIFO
   always_ff @(posedge clk_i) begin
      if (wr_push) begin
         wr_mem[wr_wp_reg] <= '{last_n: write_last_n_i, be: write_data_i[35:32], data: write_data_i[31:0]};
      end
   end

   always_ff @(posedge clk_i) begin
      if (soft_rst) begin
         wr_wp_reg <= '0;
         wr_rp_reg <= '0;
         wr_cnt_reg <= '0;
         last_queued_reg <= 1'b0;
         pci_wr_entry_o <= '0;
         pci_wr_entry_valid_o <= 1'b0;
         pci_wr_req_o <= 1'b0;
         write_fifo_almost_full_o <= 1'b0;
         write_fifo_full_o <= 1'b0;
         write_fifo_empty_n_o <= 1'b0;
      end else begin
         wr_wp_reg <= wr_wp_reg + AW'(wr_push);
         wr_rp_reg <= wr_rp_reg + AW'(wr_pop);
         wr_cnt_reg <= wr_cnt_next;
         pci_wr_entry_valid_o <= wr_pop;
         if (wr_pop) begin
            pci_wr_entry_o <= wr_mem[wr_rp_reg];
         end
         if (wr_push && !write_last_n_i) begin
            last_queued_reg <= 1'b1;
         end else if (wr_pop && !wr_mem[wr_rp_reg].last_n) begin
            last_queued_reg <= 1'b0;
         end
         // With bus hold the write waits for the whole burst to be queued
         pci_wr_req_o <= wr_cnt_next != '0 && (!hold || last_queued_reg || (wr_push && !write_last_n_i));
         write_fifo_almost_full_o <= wr_cnt_next >= AFULL_CNT;
         write_fifo_full_o <= wr_cnt_next == FULL_CNT;
         write_fifo_empty_n_o <= wr_cnt_next != '0;
      end
   end

   // Master read FIFO; byte enables go to the bus, never into storage
   always_ff @(posedge clk_i) begin
      if (rd_push) begin
         rd_mem[rd_wp_reg] <= pci_rd_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (soft_rst) begin
         rd_wp_reg <= '0;
         rd_rp_reg <= '0;
         rd_cnt_reg <= '0;
         read_data_o <= '0;
         read_fifo_almost_empty_n_o <= 1'b0;
         read_fifo_empty_n_o <= 1'b0;
         read_fifo_full_n_o <= 1'b1;
         pci_wait_o <= 1'b0;
      end else begin
         rd_wp_reg <= rd_wp_reg + AW'(rd_push);
         rd_rp_reg <= rd_rp_reg + AW'(rd_pop);
         rd_cnt_reg <= rd_cnt_next;
         if (rd_pop) begin
            read_data_o <= rd_mem[rd_rp_reg];
         end
         read_fifo_almost_empty_n_o <= rd_cnt_next > ALMOST_CNT;
         read_fifo_empty_n_o <= rd_cnt_next != '0;
         read_fifo_full_n_o <= rd_cnt_next != FULL_CNT;
         pci_wait_o <= rd_cnt_next == FULL_CNT;
      end
   end

   // PCI engine request fields
   always_ff @(posedge clk_i) begin
      if (soft_rst) begin
         pci_rd_req_o <= 1'b0;
         pci_addr_o <= '0;
         pci_cmd_o <= '0;
         pci_be_o <= '0;
         pci_burst_o <= 1'b0;
         pci_stop_o <= 1'b0;
      end else begin
         pci_rd_req_o <= rd_active_reg && !rd_end;
         pci_addr_o <= addr_reg;
         pci_cmd_o <= cmd_reg;
         pci_be_o <= is_read_reg ? rd_be_reg : 8'h00;
         pci_burst_o <= !addr_reg[pci_master_pkg::SINGLE_ADDR_BIT];
         pci_stop_o <= !burst_stop_n_i && rd_active_reg;
      end
   end

   // Master ready held low during a clear and a fixed time after it
   always_ff @(posedge clk_i) begin
      if (soft_rst) begin
         ready_cnt_reg <= 4'(pci_master_pkg::READY_HOLD_CYC);
         master_ready_o <= 1'b0;
      end else begin
         if (ready_cnt_reg != '0) begin
            ready_cnt_reg <= ready_cnt_reg - 4'h1;
         end
         master_ready_o <= ready_cnt_reg <= 4'h1;
      end
   end

   // Error status: OR while select high, serial one bit per clock while low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_idx_reg <= 2'h0;
         error_status_o <= 1'b0;
      end else if (status_shift_en_n_i) begin
         shift_idx_reg <= 2'h0;
         error_status_o <= |pci_status_i;
      end else begin
         shift_idx_reg <= (shift_idx_reg == 2'(pci_master_pkg::STATUS_BITS - 1)) ? 2'h0 : shift_idx_reg + 2'h1;
         error_status_o <= pci_status_i[shift_idx_reg];
      end
   end

   // Wishbone slave, one wait state, unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= pci_master_pkg::CTRL_RESET;
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == pci_master_pkg::REG_CTRL && wb_sel_i[0]) begin
            ctrl_reg <= wb_dat_i[2:0];
         end
         wb_dat_o <= '0;
         if (wb_req && !wb_we_i) begin
            if (wb_adr_i == pci_master_pkg::REG_CTRL) begin
               wb_dat_o <= {29'h0, ctrl_reg};
            end else if (wb_adr_i == pci_master_pkg::REG_STATUS) begin
               wb_dat_o[pci_master_pkg::STAT_STATE_LSB +: 3] <= state_counter_o;
               wb_dat_o[pci_master_pkg::STAT_ERR_LSB +: 3] <= pci_status_i;
               wb_dat_o[pci_master_pkg::STAT_READY_BIT] <= master_ready_o;
               wb_dat_o[pci_master_pkg::STAT_WR_ACTIVE_BIT] <= pci_wr_req_o;
               wb_dat_o[pci_master_pkg::STAT_RD_ACTIVE_BIT] <= rd_active_reg;
            end
         end
      end
   end
endmodule

// [tb/pci_master_user_port_checker.sv]
// Pin-level assertions for the master user port
`timescale 1ns/1ps
module pci_master_user_port_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Watched pins
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [2:0] state_counter_o,
   input wire logic write_fifo_almost_full_o,
   input wire logic write_fifo_full_o,
   input wire logic read_fifo_almost_empty_n_o,
   input wire logic read_fifo_empty_n_o,
   input wire logic burst_stop_n_i,
   input wire logic termination_done_n_o,
   input wire logic status_shift_en_n_i,
   input wire logic error_status_o,
   input wire logic [2:0] pci_status_i,
   input wire logic master_side_clear_n_i,
   input wire logic master_ready_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_err_or: assert property (
      $past(status_shift_en_n_i) && !$past(rst_i) |-> error_status_o == |$past(pci_status_i))
      else $error("error status is not the OR of the status bits");
   a_err_serial: assert property (
      $fell(status_shift_en_n_i) |=> (error_status_o == $past(pci_status_i[0])) ##1
         ($past(status_shift_en_n_i) || error_status_o == $past(pci_status_i[1])))
      else $error("serial status bits out of order");
   a_state_code: assert property (
      state_counter_o inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5})
      else $error("state counter shows an unknown code");
   a_state_hi: assert property (
      state_counter_o == pci_master_pkg::CNT_DATA_HI |=> state_counter_o inside {3'h4, 3'h0})
      else $error("upper data state not followed by lower data or idle");
   a_wfifo_flags: assert property (
      write_fifo_full_o |-> write_fifo_almost_full_o)
      else $error("write fifo full without almost full");
   a_rfifo_flags: assert property (
      !read_fifo_empty_n_o |-> !read_fifo_almost_empty_n_o)
      else $error("read fifo empty without almost empty");
   a_term_release: assert property (
      $rose(burst_stop_n_i) |-> ##[1:2] termination_done_n_o)
      else $error("termination flag stuck after stop release");
   a_ready_clear: assert property (
      !master_side_clear_n_i |=> !master_ready_o)
      else $error("ready high during clear");
   a_ready_hold: assert property (
      $rose(master_side_clear_n_i) |-> (!master_ready_o) [*8] ##[1:3] master_ready_o)
      else $error("ready gap after clear out of range");
   a_wb_ack: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus acknowledge not a single next-cycle pulse");
endmodule
bind pci_master_user_port pci_master_user_port_checker chk (.*);

// [tb/pci_engine_model.sv]
// Bus-side engine model: drains write entries and returns read dwords
`timescale 1ns/1ps
module pci_engine_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Requests from the port
   input wire logic wr_req_i,
   input wire logic rd_req_i,
   input wire logic wait_i,
   input wire logic entry_valid_i,
   input wire pci_master_pkg::wr_entry_s entry_i,
   input wire logic slow_i,
   // Answers to the port
   output logic pop_o,
   output logic push_o,
   output logic [31:0] data_o
);
   pci_master_pkg::wr_entry_s got[$];
   int n_push = 0;
   logic tick, go;
   assign go = !rst_i && rd_req_i && !wait_i && (!slow_i || tick);
   always @(posedge clk_i) begin
      tick <= !rst_i && !tick;
      pop_o <= !rst_i && wr_req_i && (!slow_i || tick);
      if (entry_valid_i) got.push_back(entry_i);
   end
   // Holds off while waits are asked for, then resumes from the same dword
   always @(posedge clk_i) begin
      push_o <= go;
      data_o <= rst_i ? 32'h0 : go ? 32'h5A00_0000 + 32'(n_push) : ~data_o;
      if (go) n_push <= n_push + 1;
   end
endmodule

// [tb/pci_master_user_port_test.sv]
// Self-checking bench for the master user port
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module pci_master_user_port_test;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00, pci_be_o;
   logic [3:0] wb_sel_i = 4'hF, pci_cmd_o;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, read_data_o, pci_rd_data_i, q;
   logic addr_en_n_i = 1'b1, write_data_en_n_i = 1'b1, write_last_n_i = 1'b1, read_data_en_n_i = 1'b1;
   logic [35:0] write_data_i = 36'h0;
   logic [2:0] state_counter_o, pci_status_i = 3'h0;
   logic write_fifo_almost_full_o, write_fifo_full_o, write_fifo_empty_n_o, read_fifo_almost_empty_n_o;
   logic read_fifo_empty_n_o, read_fifo_full_n_o, burst_stop_n_i = 1'b1, termination_done_n_o;
   logic status_shift_en_n_i = 1'b1, error_status_o, master_side_clear_n_i = 1'b1, master_ready_o;
   logic pci_wr_req_o, pci_wr_pop_i, pci_wr_entry_valid_o, pci_rd_req_o, pci_rd_push_i, pci_abort_i = 1'b0;
   logic [63:0] pci_addr_o;
   logic pci_burst_o, pci_wait_o, pci_stop_o, slow = 1'b0;
   pci_master_pkg::wr_entry_s pci_wr_entry_o;
   int err_total = 0, samples_checked = 0, base;
   pci_master_user_port dut (.*);
   pci_engine_model eng (.clk_i(clk_i), .rst_i(rst_i), .wr_req_i(pci_wr_req_o), .rd_req_i(pci_rd_req_o),
      .wait_i(pci_wait_o), .entry_valid_i(pci_wr_entry_valid_o), .entry_i(pci_wr_entry_o), .slow_i(slow),
      .pop_o(pci_wr_pop_i), .push_o(pci_rd_push_i), .data_o(pci_rd_data_i));
   always #5 clk_i = ~clk_i;
   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      `CHK("wb_ack", 1'b1, wb_ack_o)
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   // Drives one setup or data word; checks the state left by the previous one
   task automatic uw(input logic a_n, d_n, l_n, input logic [35:0] w, input logic [2:0] st);
      @(posedge clk_i);
      addr_en_n_i <= a_n;
      write_data_en_n_i <= d_n;
      write_last_n_i <= l_n;
      write_data_i <= w;
      #1 `CHK("state", st, state_counter_o)
   endtask
   task automatic wait_on(ref logic s, input logic v, input string n);
      for (int k = 0; k < 400 && s !== v; k++) @(posedge clk_i);
      `CHK(n, v, s)
   endtask
   task automatic drain(input int n, input logic chk);
      for (int i = 0; i <= n; i++) begin
         @(posedge clk_i);
         read_data_en_n_i <= (i == n);
         #1 if (chk && i > 0) `CHK("rd_data", 32'h5A00_0000 + 32'(base + i - 1), read_data_o)
      end
   endtask
   task automatic rd_setup(input logic [17:0] cnt, input logic [31:0] a);
      base = eng.n_push;
      uw(1'b0, 1'b1, 1'b1, {4'h6, 6'h00, 8'hA5, cnt}, pci_master_pkg::CNT_IDLE);
      uw(1'b0, 1'b1, 1'b1, {4'h0, a}, pci_master_pkg::CNT_SETUP1);
      uw(1'b1, 1'b1, 1'b1, 36'h0, pci_master_pkg::CNT_DATA_LO);
      @(posedge clk_i);
      #1 `CHK("burst", ~a[2], pci_burst_o)
      `CHK("rd_be", 8'hA5, pci_be_o)
      `CHK("cmd", 4'h6, pci_cmd_o)
   endtask
   task automatic t_write(input logic w64);
      int n;
      n = w64 ? 4 : 3;
      base = eng.got.size();
      slow <= w64;
      wb(1'b1, pci_master_pkg::REG_CTRL, {30'h0, w64, w64});
      uw(1'b0, 1'b1, 1'b1, {4'h7, 32'h0000_1000}, pci_master_pkg::CNT_IDLE);
      if (w64) uw(1'b0, 1'b1, 1'b0, 36'h0, pci_master_pkg::CNT_SETUP1);
      for (int i = 0; i < n; i++) uw(1'b1, 1'b0, 1'(i != n - 1), {4'hF, 32'hC0DE_0000 + 32'(i)},
         (w64 && i[0]) ? pci_master_pkg::CNT_DATA_HI : pci_master_pkg::CNT_DATA_LO);
      uw(1'b1, 1'b1, 1'b1, 36'h0, pci_master_pkg::CNT_IDLE);
      for (int k = 0; k < 200 && eng.got.size() < base + n; k++) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         `CHK("wr_data", 32'hC0DE_0000 + 32'(i), eng.got[base + i].data)
         `CHK("wr_last", 1'(i != n - 1), eng.got[base + i].last_n)
      end
   endtask
   task automatic t_read;
      wb(1'b1, pci_master_pkg::REG_CTRL, 32'h0);
      rd_setup(18'd3, 32'h0000_2000);
      for (int k = 0; k < 200 && eng.n_push < base + 6; k++) @(posedge clk_i);
      repeat (3) @(posedge clk_i);
      `CHK("aempty_n", 1'b1, read_fifo_almost_empty_n_o)
      `CHK("addr", 64'h2018, pci_addr_o)
      drain(6, 1'b1);
      repeat (3) @(posedge clk_i);
      `CHK("empty_n", 1'b0, read_fifo_empty_n_o)
      `CHK("aempty_n", 1'b0, read_fifo_almost_empty_n_o)
      rd_setup(18'd3, 32'h0000_2004);
      repeat (20) @(posedge clk_i);
      `CHK("aempty_n", 1'b0, read_fifo_almost_empty_n_o)
      drain(4, 1'b0);
      repeat (3) @(posedge clk_i);
      `CHK("state", pci_master_pkg::CNT_IDLE, state_counter_o)
   endtask
   task automatic t_stop;
      rd_setup(18'd40, 32'h0000_4000);
      wait_on(read_fifo_full_n_o, 1'b0, "full_n");
      repeat (4) @(posedge clk_i);
      `CHK("wait", 1'b1, pci_wait_o)
      `CHK("rd_req", 1'b1, pci_rd_req_o)
      burst_stop_n_i <= 1'b0;
      drain(1, 1'b1);
      `CHK("stop", 1'b1, pci_stop_o)
      wait_on(termination_done_n_o, 1'b0, "term_n");
      `CHK("rd_req", 1'b0, pci_rd_req_o)
      burst_stop_n_i <= 1'b1;
      drain(70, 1'b0);
      repeat (3) @(posedge clk_i);
      `CHK("empty_n", 1'b0, read_fifo_empty_n_o)
   endtask
   task automatic t_status;
      pci_status_i <= 3'b100;
      repeat (3) @(posedge clk_i);
      `CHK("err_or", 1'b1, error_status_o)
      pci_status_i <= 3'b101;
      status_shift_en_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      `CHK("err_bit0", 1'b1, error_status_o)
      @(posedge clk_i);
      `CHK("err_bit1", 1'b0, error_status_o)
      @(posedge clk_i);
      `CHK("err_bit2", 1'b1, error_status_o)
      status_shift_en_n_i <= 1'b1;
      pci_status_i <= 3'b000;
      repeat (3) @(posedge clk_i);
      `CHK("err_or", 1'b0, error_status_o)
   endtask
   task automatic t_fill_clear;
      int n;
      wb(1'b1, pci_master_pkg::REG_CTRL, 32'h0000_0004);
      uw(1'b0, 1'b1, 1'b1, {4'h7, 32'h0000_8000}, pci_master_pkg::CNT_IDLE);
      for (int i = 0; i < 64; i++) begin
         uw(1'b1, 1'b0, 1'b1, {4'hF, 32'(i)}, pci_master_pkg::CNT_DATA_LO);
         if (i == 59 || i == 63) begin
            uw(1'b1, 1'b1, 1'b1, 36'h0, pci_master_pkg::CNT_DATA_LO);
            repeat (2) @(posedge clk_i);
            `CHK("afull", 1'b1, write_fifo_almost_full_o)
            `CHK("full", 1'(i == 63), write_fifo_full_o)
            `CHK("wr_req", 1'b0, pci_wr_req_o)
         end
      end
      master_side_clear_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CHK("ready", 1'b0, master_ready_o)
      master_side_clear_n_i <= 1'b1;
      n = 0;
      while (master_ready_o !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      `CHK("ready_gap", 1'b1, n >= 9 && n <= 11)
      `CHK("wr_empty_n", 1'b0, write_fifo_empty_n_o)
      `CHK("state", pci_master_pkg::CNT_IDLE, state_counter_o)
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_on(master_ready_o, 1'b1, "ready");
      wb(1'b1, pci_master_pkg::REG_CTRL, 32'h0000_0005);
      wb(1'b0, pci_master_pkg::REG_CTRL, 32'h0);
      `CHK("ctrl", 32'h0000_0005, q)
      wb(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 32'h0, q)
      t_write(1'b0);
      t_write(1'b1);
      t_read();
      t_stop();
      t_status();
      t_fill_clear();
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      end_of_test();
   end
endmodule
